// ### core/eswc_pkg.sv
// shared constants for the enable, sleep and wake control block
package eswc_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned LP_ENTRY_US     = 1000;
    localparam int unsigned CE_WAKE_LOW_US  = 250;
    localparam int unsigned HV_WAKE_LOW_US  = 250;
    localparam int unsigned LIN_WAKE_LOW_US = 150;
    localparam int unsigned GATE_OFF_NS     = 100;
    // cycle counts, least times rounded up
    localparam int unsigned LP_ENTRY_CYC     = (LP_ENTRY_US * 1000 + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
    localparam int unsigned CE_WAKE_LOW_CYC  = (CE_WAKE_LOW_US * 1000 + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
    localparam int unsigned HV_WAKE_LOW_CYC  = (HV_WAKE_LOW_US * 1000 + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
    localparam int unsigned LIN_WAKE_LOW_CYC = (LIN_WAKE_LOW_US * 1000 + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
    // longest time rounded down
    localparam int unsigned GATE_OFF_CYC     = GATE_OFF_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W            = 20;
    localparam int unsigned DT_W             = 4;
    localparam logic [DT_W-1:0] DT_RESET     = 4'h0;

    typedef enum logic [1:0] {
        ESWC_ACTIVE  = 2'b00,
        ESWC_STANDBY = 2'b01,
        ESWC_SLEEP   = 2'b10
    } eswc_mode_e;
endpackage

// ### core/eswc_low_timer.sv
// low-level duration detector with rising-edge qualify
`timescale 1ns/1ps
module eswc_low_timer #(
    parameter int unsigned CNT_W   = 20,
    parameter int unsigned MIN_CYC = 25000
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic srst_in,
    // watched level
    input  wire logic level_in,
    // results
    output logic      long_low_out,
    output logic      rise_after_long_out
);
    localparam logic [CNT_W-1:0] MIN_V = CNT_W'(MIN_CYC);
    logic [CNT_W-1:0] cnt_r;
    logic             prev_r;

    // counter saturates so a very long low never wraps back to short
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_r <= '0;
        end else if (level_in) begin
            cnt_r <= '0;
        end else if (cnt_r < MIN_V) begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= level_in;
        end
    end

    assign long_low_out        = (cnt_r >= MIN_V);
    assign rise_after_long_out = level_in && !prev_r && (cnt_r >= MIN_V);
endmodule

// ### core/eswc_top.sv
// enable, sleep and wake control with gate blanking and bus pass-through
//
// Overview of operation
// - enable low forces six gate outputs low fast
// - low-power entry only after enable low interval
// - standby disables amplifiers and 12 V regulator
// - translator variant turns 5 V regulator off
// - enable high keeps every function active
// - enable rise clears latched fault if gone
// - sleep-select bit picks sleep, else standby
// - short enable low pulse never enters low power
// - sleep wake on enable rise after long low
// - translators copy high-voltage input, open-drain
// - pull-up bit drives pull-ups, sampled enable-low
// - sleep wake on input one rise after low
// - bus pull-up: on active, off sleep, bit standby
// - sleep wake on bus rise after dominant
// - receive output follows bus, open-drain
// - bus dominant while transmit low, permit set, active
// - dead time from host dead_time_in input only
// - transmit permit pulse latches, fault pulls low
`timescale 1ns/1ps
module eswc_top #(
    parameter int unsigned LP_ENTRY_CYC     = eswc_pkg::LP_ENTRY_CYC,
    parameter int unsigned CE_WAKE_LOW_CYC  = eswc_pkg::CE_WAKE_LOW_CYC,
    parameter int unsigned HV_WAKE_LOW_CYC  = eswc_pkg::HV_WAKE_LOW_CYC,
    parameter int unsigned LIN_WAKE_LOW_CYC = eswc_pkg::LIN_WAKE_LOW_CYC,
    parameter bit          HAS_TRANSLATORS  = 1'b0
) (
    // clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      srst_in,
    // host enable and configuration bits
    input  wire logic                      chip_enable_in,
    input  wire logic                      sleep_select_in,
    input  wire logic                      bus_pullup_select_in,
    input  wire logic [eswc_pkg::DT_W-1:0] dead_time_in,
    // pwm inputs
    input  wire logic                      phase_a_high_drive_in,
    input  wire logic                      phase_b_high_drive_in,
    input  wire logic                      phase_c_high_drive_in,
    input  wire logic                      phase_a_low_drive_in,
    input  wire logic                      phase_b_low_drive_in,
    input  wire logic                      phase_c_low_drive_in,
    // gate outputs
    output logic                           phase_a_high_gate_out,
    output logic                           phase_b_high_gate_out,
    output logic                           phase_c_high_gate_out,
    output logic                           phase_a_low_gate_out,
    output logic                           phase_b_low_gate_out,
    output logic                           phase_c_low_gate_out,
    // fault sources and state
    input  wire logic                      hw_fault_in,
    output logic                           fault_latched_out,
    // power domain enables and mode
    output logic                           amp_enable_out,
    output logic                           reg12_enable_out,
    output logic                           reg5_enable_out,
    output logic                           buck_enable_out,
    output logic                           monitor_enable_out,
    output logic [1:0]                     mode_out,
    // level translators
    input  wire logic                      high_volt_input_one_in,
    input  wire logic                      high_volt_input_two_in,
    output logic                           translated_output_one_out,
    output logic                           translated_output_one_oe_out,
    output logic                           translated_output_two_out,
    output logic                           translated_output_two_oe_out,
    output logic                           hv_pullup_enable_out,
    // bus transceiver
    input  wire logic                      bus_line_in,
    output logic                           bus_line_out,
    output logic                           bus_line_oe_out,
    output logic                           bus_pullup_enable_out,
    input  wire logic                      tx_data_in,
    output logic                           rx_data_out,
    output logic                           rx_data_oe_out,
    input  wire logic                      bus_fault_in,
    input  wire logic                      fault_and_tx_permit_pin_in,
    output logic                           fault_and_tx_permit_pin_out,
    output logic                           fault_and_tx_permit_pin_oe_out
);
    localparam logic [eswc_pkg::CNT_W-1:0] LP_V = eswc_pkg::CNT_W'(LP_ENTRY_CYC);

    eswc_pkg::eswc_mode_e mode_r;
    eswc_pkg::eswc_mode_e mode_nxt;
    logic [eswc_pkg::CNT_W-1:0] ce_low_cnt_r;
    logic       ce_prev_r;
    logic       ce_rise;
    logic       ce_wake;
    logic       hv_wake;
    logic       lin_wake;
    logic       fault_r;
    logic       pullup_sel_r;
    logic       tx_permit_r;
    logic [5:0] gate_r;
    logic [5:0] pwm_req;
    logic [5:0] pwm_dt;
    logic [eswc_pkg::DT_W-1:0] dt_cnt_r [3];
    logic [2:0] hi_prev_r;
    logic [2:0] lo_prev_r;

    assign ce_rise = chip_enable_in && !ce_prev_r;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ce_prev_r <= 1'b0;
        end else begin
            ce_prev_r <= chip_enable_in;
        end
    end

    // saturating low-time counter of the enable pin
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ce_low_cnt_r <= '0;
        end else if (chip_enable_in) begin
            ce_low_cnt_r <= '0;
        end else if (ce_low_cnt_r < LP_V) begin
            ce_low_cnt_r <= ce_low_cnt_r + eswc_pkg::CNT_W'(1);
        end
    end

    eswc_low_timer #(
        .CNT_W   (eswc_pkg::CNT_W),
        .MIN_CYC (CE_WAKE_LOW_CYC)
    ) u_ce_wake (
        .clk_in              (clk_in),
        .srst_in             (srst_in),
        .level_in            (chip_enable_in),
        .long_low_out        (),
        .rise_after_long_out (ce_wake)
    );

    eswc_low_timer #(
        .CNT_W   (eswc_pkg::CNT_W),
        .MIN_CYC (HV_WAKE_LOW_CYC)
    ) u_hv_wake (
        .clk_in              (clk_in),
        .srst_in             (srst_in),
        .level_in            (high_volt_input_one_in),
        .long_low_out        (),
        .rise_after_long_out (hv_wake)
    );

    eswc_low_timer #(
        .CNT_W   (eswc_pkg::CNT_W),
        .MIN_CYC (LIN_WAKE_LOW_CYC)
    ) u_lin_wake (
        .clk_in              (clk_in),
        .srst_in             (srst_in),
        .level_in            (bus_line_in),
        .long_low_out        (),
        .rise_after_long_out (lin_wake)
    );

    // mode sequencing; short enable lows never reach the entry count
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            eswc_pkg::ESWC_ACTIVE: begin
                if (!chip_enable_in && ce_low_cnt_r >= LP_V - eswc_pkg::CNT_W'(1)) begin
                    mode_nxt = sleep_select_in ? eswc_pkg::ESWC_SLEEP
                                               : eswc_pkg::ESWC_STANDBY;
                end
            end
            eswc_pkg::ESWC_STANDBY: begin
                if (chip_enable_in) begin
                    mode_nxt = eswc_pkg::ESWC_ACTIVE;
                end
            end
            eswc_pkg::ESWC_SLEEP: begin
                // enable-pin wake needs its own long low, the other sources are
                // only relevant with the matching variant wired up
                if (ce_wake) begin
                    mode_nxt = eswc_pkg::ESWC_ACTIVE;
                end else if (HAS_TRANSLATORS && hv_wake) begin
                    mode_nxt = eswc_pkg::ESWC_STANDBY;
                end else if (!HAS_TRANSLATORS && lin_wake) begin
                    mode_nxt = eswc_pkg::ESWC_STANDBY;
                end
            end
            default: mode_nxt = eswc_pkg::ESWC_ACTIVE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mode_r <= eswc_pkg::ESWC_ACTIVE;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // fault clears only on enable rise with cause gone; a new fault wins
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            fault_r <= 1'b0;
        end else if (hw_fault_in) begin
            fault_r <= 1'b1;
        end else if (ce_rise) begin
            fault_r <= 1'b0;
        end
    end

    // configuration bit sampled only while enable is low
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pullup_sel_r <= 1'b0;
        end else if (!chip_enable_in) begin
            pullup_sel_r <= bus_pullup_select_in;
        end
    end

    // dead-time insertion: a rising drive waits dead_time_in plus one cycles after the
    // opposite side fell; zero passes non-overlapping host waveforms through unchanged
    assign pwm_req = {phase_c_high_drive_in, phase_b_high_drive_in, phase_a_high_drive_in,
                      phase_c_low_drive_in,  phase_b_low_drive_in,  phase_a_low_drive_in};

    // one process for all phases keeps every counter on a single driver
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            for (int p = 0; p < 3; p++) begin
                dt_cnt_r[p] <= eswc_pkg::DT_RESET;
            end
            hi_prev_r <= '0;
            lo_prev_r <= '0;
        end else begin
            hi_prev_r <= pwm_dt[5:3];
            lo_prev_r <= pwm_dt[2:0];
            for (int p = 0; p < 3; p++) begin
                if ((hi_prev_r[p] && !pwm_dt[p+3]) || (lo_prev_r[p] && !pwm_dt[p])) begin
                    dt_cnt_r[p] <= dead_time_in;
                end else if (dt_cnt_r[p] != '0) begin
                    dt_cnt_r[p] <= dt_cnt_r[p] - eswc_pkg::DT_W'(1);
                end
            end
        end
    end

    for (genvar p = 0; p < 3; p++) begin : g_phase
        // shoot-through guard: never both sides of one phase together; the
        // opposite side still on last cycle blocks a rise before the count loads
        assign pwm_dt[p+3] = pwm_req[p+3] && !pwm_req[p] && (hi_prev_r[p] ||
                             dead_time_in == '0 || (dt_cnt_r[p] == '0 && !lo_prev_r[p]));
        assign pwm_dt[p]   = pwm_req[p] && !pwm_req[p+3] && (lo_prev_r[p] ||
                             dead_time_in == '0 || (dt_cnt_r[p] == '0 && !hi_prev_r[p]));
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            gate_r <= '0;
        end else begin
            gate_r <= pwm_dt;
        end
    end

    // gate outputs blanked combinationally so disable acts within one cycle
    logic gate_ok;
    assign gate_ok = chip_enable_in && (mode_r == eswc_pkg::ESWC_ACTIVE);
    assign phase_a_low_gate_out  = gate_r[0] && gate_ok;
    assign phase_b_low_gate_out  = gate_r[1] && gate_ok;
    assign phase_c_low_gate_out  = gate_r[2] && gate_ok;
    assign phase_a_high_gate_out = gate_r[3] && gate_ok;
    assign phase_b_high_gate_out = gate_r[4] && gate_ok;
    assign phase_c_high_gate_out = gate_r[5] && gate_ok;

    // power domain enables
    logic awake;
    assign awake              = chip_enable_in && (mode_r == eswc_pkg::ESWC_ACTIVE);
    assign amp_enable_out     = awake;
    assign reg12_enable_out   = awake;
    assign reg5_enable_out    = HAS_TRANSLATORS ? chip_enable_in : 1'b1;
    assign buck_enable_out    = (mode_r != eswc_pkg::ESWC_SLEEP);
    assign monitor_enable_out = (mode_r != eswc_pkg::ESWC_SLEEP);
    assign mode_out           = mode_r;
    assign fault_latched_out  = fault_r;

    // translators and pull-ups; open-drain drives only the low level
    assign translated_output_one_out    = 1'b0;
    assign translated_output_one_oe_out = !high_volt_input_one_in;
    assign translated_output_two_out    = 1'b0;
    assign translated_output_two_oe_out = !high_volt_input_two_in;
    assign hv_pullup_enable_out         = pullup_sel_r;

    always_comb begin
        case (mode_r)
            eswc_pkg::ESWC_ACTIVE:  bus_pullup_enable_out = 1'b1;
            eswc_pkg::ESWC_SLEEP:   bus_pullup_enable_out = 1'b0;
            default:                bus_pullup_enable_out = pullup_sel_r;
        endcase
    end

    // transmit permit latch; a bus fault pulls the pin low and wins the pulse
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_permit_r <= 1'b0;
        end else if (bus_fault_in) begin
            tx_permit_r <= 1'b0;
        end else if (fault_and_tx_permit_pin_in) begin
            tx_permit_r <= 1'b1;
        end
    end

    assign fault_and_tx_permit_pin_out    = tx_permit_r && !bus_fault_in;
    assign fault_and_tx_permit_pin_oe_out = tx_permit_r || bus_fault_in;

    // bus driver is only allowed dominant once transmit is permitted
    assign bus_line_out    = 1'b0;
    assign bus_line_oe_out = !tx_data_in && tx_permit_r && awake;
    assign rx_data_out     = 1'b0;
    assign rx_data_oe_out  = !bus_line_in;

    a_gate_blank: assert property (@(posedge clk_in) disable iff (srst_in)
        !chip_enable_in |-> !(phase_a_high_gate_out || phase_b_high_gate_out ||
        phase_c_high_gate_out || phase_a_low_gate_out || phase_b_low_gate_out ||
        phase_c_low_gate_out))
        else $error("gate output high while enable low");
    a_short_low_stays: assert property (@(posedge clk_in) disable iff (srst_in)
        (mode_r == eswc_pkg::ESWC_ACTIVE && ce_low_cnt_r < LP_V - eswc_pkg::CNT_W'(1))
        |=> mode_r == eswc_pkg::ESWC_ACTIVE)
        else $error("low power entered before interval");
    a_entry_kind: assert property (@(posedge clk_in) disable iff (srst_in)
        (mode_r == eswc_pkg::ESWC_ACTIVE && mode_nxt != eswc_pkg::ESWC_ACTIVE)
        |=> mode_r == ($past(sleep_select_in) ? eswc_pkg::ESWC_SLEEP : eswc_pkg::ESWC_STANDBY))
        else $error("wrong low power mode chosen");
    a_entry_due: assert property (@(posedge clk_in) disable iff (srst_in)
        (mode_r == eswc_pkg::ESWC_ACTIVE && !chip_enable_in &&
        ce_low_cnt_r == LP_V - eswc_pkg::CNT_W'(1))
        |=> mode_r != eswc_pkg::ESWC_ACTIVE)
        else $error("low power not entered after interval");
    a_fault_clear: assert property (@(posedge clk_in) disable iff (srst_in)
        (fault_r && ce_rise && !hw_fault_in) |=> !fault_r)
        else $error("fault not cleared on enable rise");
    a_fault_hold: assert property (@(posedge clk_in) disable iff (srst_in)
        (fault_r && !ce_rise) |=> fault_r)
        else $error("fault cleared without enable rise");
    a_ce_wake: assert property (@(posedge clk_in) disable iff (srst_in)
        (mode_r == eswc_pkg::ESWC_SLEEP && ce_wake) |=> mode_r == eswc_pkg::ESWC_ACTIVE)
        else $error("no wake on enable rise");
    a_pullup_mode: assert property (@(posedge clk_in) disable iff (srst_in)
        mode_r == eswc_pkg::ESWC_SLEEP |-> !bus_pullup_enable_out)
        else $error("bus pull-up on in sleep");
    a_bus_copy: assert property (@(posedge clk_in) disable iff (srst_in)
        rx_data_oe_out == !bus_line_in && translated_output_one_oe_out == !high_volt_input_one_in)
        else $error("receive or translator path wrong");
    a_lp_power: assert property (@(posedge clk_in) disable iff (srst_in)
        mode_r == eswc_pkg::ESWC_STANDBY |-> !amp_enable_out && !reg12_enable_out &&
        buck_enable_out && monitor_enable_out)
        else $error("standby power domains wrong");
endmodule

// ### test/eswc_lin_master.sv
// bus master and host pin model on the far side of the transceiver
`timescale 1ns/1ps
module eswc_lin_master (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    // bench requests
    input  wire logic       wake_go_in,
    input  wire logic [7:0] wake_len_in,
    input  wire logic       host_pulse_in,
    // device pin drives
    input  wire logic       bus_oe_in,
    input  wire logic       rx_oe_in,
    input  wire logic       permit_in,
    input  wire logic       permit_oe_in,
    // resolved wire levels
    output logic            bus_level_out,
    output logic            rx_level_out,
    output logic            permit_level_out
);
    logic [7:0] dom_cnt_r;
    // pulse length is the bench's choice, so a too short wake can be sent on purpose
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            dom_cnt_r <= 8'h00;
        end else if (wake_go_in) begin
            dom_cnt_r <= wake_len_in;
        end else if (dom_cnt_r != 8'h00) begin
            dom_cnt_r <= dom_cnt_r - 8'h01;
        end
    end
    // master pull-up makes a released bus recessive; rx has its external pull-up
    assign bus_level_out    = !(bus_oe_in || (dom_cnt_r != 8'h00));
    assign rx_level_out     = !rx_oe_in;
    // host drives only the start pulse, then listens; the fault resistor pulls low
    assign permit_level_out = host_pulse_in ? 1'b1 : (permit_oe_in && permit_in);
endmodule

// ### test/eswc_top_test.sv
// self-checking bench for the enable, sleep and wake control block
`timescale 1ns/1ps
module eswc_top_test;
    localparam int unsigned LP   = 50;
    localparam int unsigned CEW  = 20;
    localparam int unsigned LINW = 12;
    logic                      clk_in, srst_in, chip_enable_in, sleep_select_in, hw_fault_in;
    logic                      bus_pullup_select_in, tx_data_in, bus_fault_in, hv1, hv2;
    logic [eswc_pkg::DT_W-1:0] dead_time_in;
    logic [2:0]                hi_req, lo_req, hi_gate, lo_gate;
    logic                      fault_latched_out, amp_en, reg12_en, reg5_en, buck_en, mon_en;
    logic [1:0]                mode_out;
    logic                      tr1_oe, tr2_oe, hv_pu, bus_oe, bus_pu, rx_oe, permit, permit_oe;
    logic                      bus_lvl, rx_lvl, permit_lvl, wake_go, host_pulse;
    logic [7:0]                wake_len;
    logic [3:0]                od_out;
    int                        mismatches, check_count;

    eswc_top #(.LP_ENTRY_CYC(LP), .CE_WAKE_LOW_CYC(CEW), .HV_WAKE_LOW_CYC(20),
               .LIN_WAKE_LOW_CYC(LINW), .HAS_TRANSLATORS(1'b0)) dut (
        .clk_in, .srst_in, .chip_enable_in, .sleep_select_in, .bus_pullup_select_in,
        .dead_time_in, .hw_fault_in, .fault_latched_out, .mode_out, .tx_data_in, .bus_fault_in,
        .phase_a_high_drive_in(hi_req[0]), .phase_b_high_drive_in(hi_req[1]),
        .phase_c_high_drive_in(hi_req[2]), .phase_a_low_drive_in(lo_req[0]),
        .phase_b_low_drive_in(lo_req[1]), .phase_c_low_drive_in(lo_req[2]),
        .phase_a_high_gate_out(hi_gate[0]), .phase_b_high_gate_out(hi_gate[1]),
        .phase_c_high_gate_out(hi_gate[2]), .phase_a_low_gate_out(lo_gate[0]),
        .phase_b_low_gate_out(lo_gate[1]), .phase_c_low_gate_out(lo_gate[2]),
        .amp_enable_out(amp_en), .reg12_enable_out(reg12_en), .reg5_enable_out(reg5_en),
        .buck_enable_out(buck_en), .monitor_enable_out(mon_en),
        .high_volt_input_one_in(hv1), .high_volt_input_two_in(hv2),
        .translated_output_one_out(od_out[0]), .translated_output_one_oe_out(tr1_oe),
        .translated_output_two_out(od_out[1]), .translated_output_two_oe_out(tr2_oe),
        .hv_pullup_enable_out(hv_pu), .bus_line_in(bus_lvl), .bus_line_out(od_out[2]),
        .bus_line_oe_out(bus_oe), .bus_pullup_enable_out(bus_pu), .rx_data_out(od_out[3]),
        .rx_data_oe_out(rx_oe), .fault_and_tx_permit_pin_in(permit_lvl),
        .fault_and_tx_permit_pin_out(permit), .fault_and_tx_permit_pin_oe_out(permit_oe));

    eswc_lin_master far (.clk_in, .srst_in, .wake_go_in(wake_go), .wake_len_in(wake_len),
        .host_pulse_in(host_pulse), .bus_oe_in(bus_oe), .rx_oe_in(rx_oe), .permit_in(permit),
        .permit_oe_in(permit_oe), .bus_level_out(bus_lvl), .rx_level_out(rx_lvl),
        .permit_level_out(permit_lvl));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // bounded poll, so a mode that never arrives fails instead of hanging
    task automatic wait_mode(input logic [1:0] exp, input int n);
        repeat (n) begin
            if (mode_out === exp) break;
            tick(1);
            #1;
        end
        chk(mode_out, exp);
    endtask

    task automatic s_standby();
        tick(1);
        hi_req <= 3'h5;
        lo_req <= 3'h2;
        tick(2);
        #1;
        chk({hi_gate, lo_gate}, 8'h2a);
        chk({amp_en, reg12_en, reg5_en}, 8'h07);
        tick(1);
        chip_enable_in <= 1'b0;
        bus_pullup_select_in <= 1'b1;
        #1;
        chk({hi_gate, lo_gate}, 8'h00);
        tick(LP - 3);
        #1;
        chk(mode_out, eswc_pkg::ESWC_ACTIVE);
        wait_mode(eswc_pkg::ESWC_STANDBY, 6);
        chk({hi_gate, lo_gate}, 8'h00);
        chk({amp_en, reg12_en, buck_en, mon_en, reg5_en}, 8'h07);
        chk({bus_pu, hv_pu}, 8'h03);
        tick(1);
        bus_pullup_select_in <= 1'b0;
        tick(2);
        #1;
        chk({bus_pu, hv_pu}, 8'h00);
        tick(1);
        chip_enable_in <= 1'b1;
        #1;
        wait_mode(eswc_pkg::ESWC_ACTIVE, 3);
        chk(bus_pu, 1'b1);
        tick(1);
        bus_pullup_select_in <= 1'b1;
        tick(2);
        #1;
        chk(hv_pu, 1'b0);
        tick(1);
        hi_req <= 3'h0;
        lo_req <= 3'h0;
    endtask

    task automatic s_fault();
        tick(1);
        hw_fault_in <= 1'b1;
        chip_enable_in <= 1'b0;
        tick(LP - 5);
        chip_enable_in <= 1'b1;
        tick(2);
        #1;
        chk(mode_out, eswc_pkg::ESWC_ACTIVE);
        chk(fault_latched_out, 1'b1);
        tick(1);
        hw_fault_in <= 1'b0;
        chip_enable_in <= 1'b0;
        tick(3);
        chip_enable_in <= 1'b1;
        tick(2);
        #1;
        chk(fault_latched_out, 1'b0);
    endtask

    task automatic s_sleep();
        tick(1);
        sleep_select_in <= 1'b1;
        chip_enable_in <= 1'b0;
        #1;
        wait_mode(eswc_pkg::ESWC_SLEEP, LP + 4);
        chk({bus_pu, buck_en}, 8'h00);
        tick(1);
        wake_go <= 1'b1;
        wake_len <= 8'(LINW - 4);
        tick(1);
        wake_go <= 1'b0;
        tick(LINW + 8);
        #1;
        chk(mode_out, eswc_pkg::ESWC_SLEEP);
        tick(1);
        wake_go <= 1'b1;
        wake_len <= 8'(LINW + 8);
        tick(1);
        wake_go <= 1'b0;
        #1;
        wait_mode(eswc_pkg::ESWC_STANDBY, LINW + 14);
        tick(1);
        chip_enable_in <= 1'b1;
        #1;
        wait_mode(eswc_pkg::ESWC_ACTIVE, 3);
        tick(1);
        chip_enable_in <= 1'b0;
        #1;
        wait_mode(eswc_pkg::ESWC_SLEEP, LP + 4);
        tick(1);
        chip_enable_in <= 1'b1;
        #1;
        wait_mode(eswc_pkg::ESWC_ACTIVE, 3);
    endtask

    task automatic s_lin();
        tick(1);
        host_pulse <= 1'b1;
        tick(1);
        host_pulse <= 1'b0;
        tick(1);
        #1;
        chk({permit_lvl, permit_oe}, 8'h03);
        for (int i = 0; i < 4; i++) begin
            tick(1);
            {hv2, hv1} <= 2'(i);
            tx_data_in <= i[0];
            #1;
            chk({tr2_oe, tr1_oe}, 8'(~i & 3));
            chk({bus_oe, bus_lvl, rx_lvl}, i[0] ? 8'h03 : 8'h04);
            chk(rx_oe, !i[0]);
            chk(od_out, 8'h00);
        end
        tick(1);
        bus_fault_in <= 1'b1;
        tick(1);
        bus_fault_in <= 1'b0;
        tx_data_in <= 1'b0;
        tick(1);
        #1;
        chk({permit_lvl, bus_oe}, 8'h00);
        tick(1);
        tx_data_in <= 1'b1;
    endtask

    task automatic s_dead();
        tick(1);
        dead_time_in <= 4'h3;
        hi_req <= 3'h1;
        tick(2);
        hi_req <= 3'h0;
        lo_req <= 3'h1;
        tick(2);
        #1;
        chk(lo_gate, 3'h0);
        tick(4);
        #1;
        chk(lo_gate, 3'h1);
        tick(1);
        hi_req <= 3'h2;
        lo_req <= 3'h2;
        tick(3);
        #1;
        chk({hi_gate, lo_gate}, 8'h00);
    endtask

    task automatic results();
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // the sequence needs a few hundred cycles; this span is ample
    initial begin
        #100000;
        mismatches++;
        results();
    end

    initial begin
        mismatches = 0;
        check_count = 0;
        srst_in = 1'b1;
        chip_enable_in = 1'b1;
        tx_data_in = 1'b1;
        {sleep_select_in, bus_pullup_select_in, hw_fault_in, bus_fault_in, hv1, hv2} = '0;
        {dead_time_in, hi_req, lo_req, wake_go, host_pulse, wake_len} = '0;
        tick(3);
        srst_in <= 1'b0;
        s_standby();
        s_fault();
        s_lin();
        s_dead();
        s_sleep();
        results();
    end
endmodule
